/* File: bcg_pkg.sv */
// ----------------------------------------------------------------------------
// base clock generator constants
// ----------------------------------------------------------------------------
package bcg_pkg;

   // ----------------------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------------------
   localparam int NUM_SRC = 12;
   localparam int NUM_OUT = 12;
   localparam int NUM_FRACTIONAL_DIVIDER = 7;
   localparam int NUM_GEN = 20;
   localparam int SEL_W = 4;
   localparam int GEN_W = 5;
   localparam int SEL_SPAN = 16;

   // ----------------------------------------------------------------------------
   // source codes
   // ----------------------------------------------------------------------------
   localparam logic [3:0] SRC_RING = 4'h0;
   localparam logic [3:0] SRC_XTAL = 4'h1;
   localparam logic [3:0] SRC_PLL0 = 4'h2;
   localparam logic [3:0] SRC_PLL120 = 4'h3;
   localparam logic [3:0] SRC_PLL240 = 4'h4;
   localparam logic [3:0] SRC_FDIV0 = 4'h5;
   localparam logic [3:0] SRC_LAST = 4'hB;

   // ----------------------------------------------------------------------------
   // generator indices
   // ----------------------------------------------------------------------------
   localparam logic [4:0] GEN_SAFE = 5'h00;
   localparam logic [4:0] GEN_SYS = 5'h01;
   localparam logic [4:0] GEN_CTRL = 5'h02;
   localparam logic [4:0] GEN_RSVD = 5'h0A;
   localparam logic [4:0] GEN_FDIV0 = 5'h0C;
   localparam logic [4:0] GEN_PLL = 5'h13;

   // ----------------------------------------------------------------------------
   // reset values and timing counts (control clock cycles)
   // ----------------------------------------------------------------------------
   localparam logic [3:0] SEL_RESET = SRC_RING;
   localparam logic OUT_EN_RESET = 1'b1;
   localparam logic [5:0] ACT_WINDOW_CYC = 6'h20;
   localparam logic [5:0] STARTUP_CYC = 6'h20;
   localparam logic [5:0] FORCE_LOW_CYC = 6'h20;

   typedef enum logic [1:0] {
      SW_RUN = 2'b00,
      SW_DRAIN = 2'b01,
      SW_LOCK = 2'b10,
      SW_HOLD = 2'b11
   } bcg_sw_state_t;

   function automatic logic is_pll(input logic [3:0] s);
      is_pll = (s >= SRC_PLL0) && (s <= SRC_PLL240);
   endfunction : is_pll

   // static legality of a source for a generator
   function automatic logic sel_legal(input logic [4:0] gen, input logic [3:0] sel);
      if (sel > SRC_LAST || gen > GEN_PLL || gen == GEN_RSVD) begin
         sel_legal = 1'b0;
      end else if (gen == GEN_PLL) begin
         sel_legal = (sel == SRC_XTAL);
      end else if (gen >= GEN_FDIV0) begin
         sel_legal = (sel < SRC_FDIV0);
      end else if (gen == GEN_SAFE || gen == GEN_CTRL) begin
         sel_legal = (sel == SRC_RING);
      end else begin
         sel_legal = 1'b1;
      end
   endfunction : sel_legal

endpackage : bcg_pkg

/* File: bcg_switch.sv */
`timescale 1ns/1ps
`default_nettype none
module bcg_switch (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [3:0] req_sel,
   input wire logic [15:0] src_lvl,
   input wire logic pll_lock,
   input wire logic out_en,
   output logic clk_out,
   output logic [3:0] cur_sel,
   output logic busy
);
   bcg_pkg::bcg_sw_state_t state_r, state_nxt;
   logic [3:0] sel_r, sel_nxt;
   logic [3:0] pend_r, pend_nxt;
   logic [5:0] cnt_r, cnt_nxt;
   logic out_r, out_nxt;

   always_comb begin
      state_nxt = state_r;
      sel_nxt = sel_r;
      pend_nxt = pend_r;
      cnt_nxt = cnt_r;
      out_nxt = out_r;
      unique case (state_r)
         bcg_pkg::SW_RUN: begin
            out_nxt = src_lvl[sel_r] & out_en;
            if (req_sel != sel_r) begin
               pend_nxt = req_sel;
               cnt_nxt = 6'h00;
               state_nxt = bcg_pkg::SW_DRAIN;
            end
         end
         bcg_pkg::SW_DRAIN: begin
            // glitch free: let the old clock finish its high phase first
            if (!out_r || cnt_r == bcg_pkg::FORCE_LOW_CYC - 6'h01) begin
               // forced low: a stuck-high source must not deadlock the swap
               out_nxt = 1'b0;
               sel_nxt = pend_r;
               state_nxt = bcg_pkg::is_pll(pend_r) ? bcg_pkg::SW_LOCK : bcg_pkg::SW_HOLD;
            end else begin
               out_nxt = src_lvl[sel_r] & out_en;
               cnt_nxt = cnt_r + 6'h01;
            end
         end
         bcg_pkg::SW_LOCK: begin
            out_nxt = 1'b0;
            if (pll_lock) begin
               state_nxt = bcg_pkg::SW_HOLD;
            end
         end
         bcg_pkg::SW_HOLD: begin
            out_nxt = 1'b0;
            state_nxt = bcg_pkg::SW_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= bcg_pkg::SW_RUN;
         sel_r <= bcg_pkg::SEL_RESET;
         pend_r <= bcg_pkg::SEL_RESET;
         cnt_r <= 6'h00;
         out_r <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         sel_r <= sel_nxt;
         pend_r <= pend_nxt;
         cnt_r <= cnt_nxt;
         out_r <= out_nxt;
      end
   end

   assign clk_out = out_r;
   assign cur_sel = sel_r;
   assign busy = (state_r != bcg_pkg::SW_RUN);

endmodule : bcg_switch
`default_nettype wire

/* File: bcg_top.sv */
`timescale 1ns/1ps
`default_nettype none
module bcg_top #(
   parameter int NUM_OUT = bcg_pkg::NUM_OUT,
   parameter int NUM_FRACTIONAL_DIVIDER = bcg_pkg::NUM_FRACTIONAL_DIVIDER
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic ring_oscillator,
   input wire logic crystal_clk,
   input wire logic [2:0] pll_clk,
   input wire logic pll_lock,
   input wire logic [6:0] fractional_divider_clk,
   input wire logic bridge_wr_toggle,
   input wire logic [4:0] bridge_wr_gen,
   input wire logic [3:0] bridge_wr_sel,
   input wire logic bridge_wr_out_en,
   output logic [11:0] base_clk,
   output logic [6:0] fractional_divider_src_clk,
   output logic pll_ref_clk,
   output logic ring_osc_enable,
   output logic [11:0] clock_presence_status,
   output logic presence_valid,
   output logic [11:0] act_start,
   output logic [11:0] act_stop,
   output logic wr_accepted,
   output logic wr_rejected,
   output logic [79:0] sel_state,
   output logic [19:0] switch_busy
);
   localparam int NS = bcg_pkg::NUM_SRC;
   localparam int NG = bcg_pkg::NUM_GEN;

   // ----------------------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------------------
   // twelve outputs, seven fractional dividers
   if (NUM_OUT != bcg_pkg::NUM_OUT || NUM_FRACTIONAL_DIVIDER != bcg_pkg::NUM_FRACTIONAL_DIVIDER) begin : g_bad_size
      $error("bcg_top: output and divider counts are fixed by the source encoding");
   end
   // the source and generator codes must cover the vectors built below
   if (bcg_pkg::SRC_LAST != NS - 1 || bcg_pkg::GEN_PLL != NG - 1) begin : g_bad_codes
      $error("bcg_top: source or generator codes disagree with the vector sizes");
   end

   // ----------------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------------
   // a code past the last source reads as absent, never as unknown
   function automatic logic src_present(input logic [NS-1:0] act, input logic [3:0] sel);
      src_present = 1'b0;
      for (int i = 0; i < NS; i++) begin
         if (sel == 4'(i)) begin
            src_present = act[i];
         end
      end
   endfunction : src_present

   // generator index that owns a selector register
   function automatic logic gen_exists(input logic [4:0] gen);
      gen_exists = (gen <= bcg_pkg::GEN_PLL) && (gen != bcg_pkg::GEN_RSVD);
   endfunction : gen_exists

   // window counters stop on their last cycle and report it
   function automatic logic win_end(input logic [5:0] cnt, input logic [5:0] len);
      win_end = (cnt == len - 6'h01);
   endfunction : win_end

   // ----------------------------------------------------------------------------
   // source synchronisers and activity detectors
   // ----------------------------------------------------------------------------
   logic [NS-1:0] src_raw;
   logic [NS-1:0] src_s1_r, src_s2_r, src_s3_r;
   logic [NS-1:0] active_r, active_nxt;
   logic [NS-1:0][5:0] det_cnt_r, det_cnt_nxt;
   logic [NS-1:0] start_r, start_nxt, stop_r, stop_nxt;
   logic [5:0] startup_r, startup_nxt;
   logic valid_r, valid_nxt;
   logic lock_s1_r, lock_s2_r;

   assign src_raw = {fractional_divider_clk, pll_clk, crystal_clk, ring_oscillator};

   always_comb begin
      active_nxt = active_r;
      det_cnt_nxt = det_cnt_r;
      start_nxt = '0;
      stop_nxt = '0;
      for (int i = 0; i < NS; i++) begin
         if (src_s2_r[i] && !src_s3_r[i]) begin
            det_cnt_nxt[i] = 6'h00;
            active_nxt[i] = 1'b1;
         end else if (win_end(det_cnt_r[i], bcg_pkg::ACT_WINDOW_CYC)) begin
            active_nxt[i] = 1'b0;
         end else begin
            det_cnt_nxt[i] = det_cnt_r[i] + 6'h01;
         end
         start_nxt[i] = active_nxt[i] & ~active_r[i];
         stop_nxt[i] = ~active_nxt[i] & active_r[i];
      end
      startup_nxt = startup_r;
      valid_nxt = valid_r;
      if (win_end(startup_r, bcg_pkg::STARTUP_CYC)) begin
         valid_nxt = 1'b1;
      end else begin
         startup_nxt = startup_r + 6'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         src_s1_r <= '0;
         src_s2_r <= '0;
         src_s3_r <= '0;
         active_r <= '0;
         det_cnt_r <= '0;
         start_r <= '0;
         stop_r <= '0;
         startup_r <= 6'h00;
         valid_r <= 1'b0;
         lock_s1_r <= 1'b0;
         lock_s2_r <= 1'b0;
      end else if (ce) begin
         src_s1_r <= src_raw;
         src_s2_r <= src_s1_r;
         src_s3_r <= src_s2_r;
         active_r <= active_nxt;
         det_cnt_r <= det_cnt_nxt;
         start_r <= start_nxt;
         stop_r <= stop_nxt;
         startup_r <= startup_nxt;
         valid_r <= valid_nxt;
         lock_s1_r <= pll_lock;
         lock_s2_r <= lock_s1_r;
      end
   end

   assign clock_presence_status = active_r;
   assign presence_valid = valid_r;
   assign act_start = start_r;
   assign act_stop = stop_r;

   // ----------------------------------------------------------------------------
   // bridge write crossing
   // ----------------------------------------------------------------------------
   // the bridge holds gen, sel and enable steady around its toggle, so
   // plain two-flop copies of them are settled once the toggle edge shows
   logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
   logic [4:0] wgen_s1_r, wgen_s2_r;
   logic [3:0] wsel_s1_r, wsel_s2_r;
   logic wen_s1_r, wen_s2_r;
   logic wr_fire;

   always_ff @(posedge mclk) begin
      if (rst) begin
         tgl_s1_r <= 1'b0;
         tgl_s2_r <= 1'b0;
         tgl_s3_r <= 1'b0;
         wgen_s1_r <= 5'h00;
         wgen_s2_r <= 5'h00;
         wsel_s1_r <= 4'h0;
         wsel_s2_r <= 4'h0;
         wen_s1_r <= 1'b0;
         wen_s2_r <= 1'b0;
      end else if (ce) begin
         tgl_s1_r <= bridge_wr_toggle;
         tgl_s2_r <= tgl_s1_r;
         tgl_s3_r <= tgl_s2_r;
         wgen_s1_r <= bridge_wr_gen;
         wgen_s2_r <= wgen_s1_r;
         wsel_s1_r <= bridge_wr_sel;
         wsel_s2_r <= wsel_s1_r;
         wen_s1_r <= bridge_wr_out_en;
         wen_s2_r <= wen_s1_r;
      end
   end

   assign wr_fire = tgl_s2_r ^ tgl_s3_r;

   // ----------------------------------------------------------------------------
   // selector registers
   // ----------------------------------------------------------------------------
   logic [NG-1:0][3:0] ctrl_sel_r, ctrl_sel_nxt;
   logic [NG-1:0] out_en_r, out_en_nxt;
   logic acc_r, acc_nxt, rej_r, rej_nxt;
   logic wr_ok;
   logic wr_gen_ok;

   always_comb begin
      ctrl_sel_nxt = ctrl_sel_r;
      out_en_nxt = out_en_r;
      acc_nxt = 1'b0;
      rej_nxt = 1'b0;
      wr_gen_ok = gen_exists(wgen_s2_r);
      wr_ok = bcg_pkg::sel_legal(wgen_s2_r, wsel_s2_r) && src_present(active_r, wsel_s2_r);
      if (wr_fire) begin
         if (wr_gen_ok) begin
            out_en_nxt[wgen_s2_r] = wen_s2_r;
         end
         if (wr_ok) begin
            ctrl_sel_nxt[wgen_s2_r] = wsel_s2_r;
            acc_nxt = 1'b1;
         end else begin
            rej_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_sel_r <= {NG{bcg_pkg::SEL_RESET}};
         out_en_r <= {NG{bcg_pkg::OUT_EN_RESET}};
         acc_r <= 1'b0;
         rej_r <= 1'b0;
      end else if (ce) begin
         ctrl_sel_r <= ctrl_sel_nxt;
         out_en_r <= out_en_nxt;
         acc_r <= acc_nxt;
         rej_r <= rej_nxt;
      end
   end

   assign wr_accepted = acc_r;
   assign wr_rejected = rej_r;

   // ----------------------------------------------------------------------------
   // output and secondary generators
   // ----------------------------------------------------------------------------
   logic [15:0] src_lvl;
   logic [NG-1:0] gen_clk;

   // the model gates the synchronised source level; it is a stand-in for the
   // analog clock mux and only resolves sources slower than half of mclk
   assign src_lvl = {{(16 - NS){1'b0}}, src_s2_r};

   for (genvar g = 0; g < NG; g++) begin : g_gen
      logic en_eff;
      assign en_eff = gen_exists(5'(g)) ? out_en_r[g] : 1'b0;
      bcg_switch u_sw (
         .mclk(mclk),
         .rst(rst),
         .ce(ce),
         .req_sel(ctrl_sel_r[g]),
         .src_lvl(src_lvl),
         .pll_lock(lock_s2_r),
         .out_en(en_eff),
         .clk_out(gen_clk[g]),
         .cur_sel(sel_state[4*g +: 4]),
         .busy(switch_busy[g])
      );
   end

   assign base_clk = gen_clk[11:0];
   assign fractional_divider_src_clk = gen_clk[18:12];
   assign pll_ref_clk = gen_clk[19];

   assign ring_osc_enable = 1'b1;

   // single slow domain: mclk is the always-on control clock
   // a dead selected source is not switched away from; it only raises a stop

endmodule : bcg_top
`default_nettype wire

/* File: bcg_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module bcg_top_monitor #(
   parameter int NUM_OUT = 12,
   parameter int NUM_FRACTIONAL_DIVIDER = 7
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic ring_oscillator,
   input wire logic crystal_clk,
   input wire logic [2:0] pll_clk,
   input wire logic pll_lock,
   input wire logic [6:0] fractional_divider_clk,
   input wire logic bridge_wr_toggle,
   input wire logic [4:0] bridge_wr_gen,
   input wire logic [3:0] bridge_wr_sel,
   input wire logic bridge_wr_out_en,
   input wire logic [11:0] base_clk,
   input wire logic [6:0] fractional_divider_src_clk,
   input wire logic pll_ref_clk,
   input wire logic ring_osc_enable,
   input wire logic [11:0] clock_presence_status,
   input wire logic presence_valid,
   input wire logic [11:0] act_start,
   input wire logic [11:0] act_stop,
   input wire logic wr_accepted,
   input wire logic wr_rejected,
   input wire logic [79:0] sel_state,
   input wire logic [19:0] switch_busy
);
   localparam int SW_LIMIT = 40;
   // ----------------------------------------------------------------------------
   // cycles since reset release
   // ----------------------------------------------------------------------------
   logic [5:0] age_r;
   logic [5:0] age_nxt;
   always_comb begin
      age_nxt = age_r;
      if (age_r != 6'h3F) age_nxt = age_r + 6'h01;
   end
   always_ff @(posedge mclk) begin
      if (rst) age_r <= 6'h00;
      else if (ce) age_r <= age_nxt;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------------------
   // switch steps
   // ----------------------------------------------------------------------------
   sequence sw_enter(int g);
      $rose(switch_busy[g]);
   endsequence
   sequence sw_leave(int g);
      !switch_busy[g];
   endsequence
   property sw_bounded(int g);
      sw_enter(g) |-> ##[1:SW_LIMIT] sw_leave(g);
   endproperty
   chk_ring_always_on: assert property (ring_osc_enable)
      else $error("ring enable dropped");
   chk_rsvd_out_low: assert property (!base_clk[10])
      else $error("reserved output toggled");
   chk_safe_ring_only: assert property (sel_state[3:0] == 4'h0 && sel_state[11:8] == 4'h0)
      else $error("safe or control clock left ring");
   chk_pll_ref_xtal: assert property (sel_state[79:76] <= 4'h1)
      else $error("pll reference off crystal");
   chk_reset_ring: assert property ($fell(rst) |-> sel_state == '0 && switch_busy == '0)
      else $error("selection not ring after reset");
   chk_absent_start: assert property ($fell(rst) |-> clock_presence_status == '0)
      else $error("source present right after reset");
   chk_valid_timing: assert property ($rose(presence_valid) |-> age_r inside {[6'h1E:6'h22]})
      else $error("presence valid at wrong time");
   chk_valid_holds: assert property (presence_valid |=> presence_valid)
      else $error("presence valid dropped");
   chk_start_pulse: assert property (act_start == (clock_presence_status & ~$past(clock_presence_status)))
      else $error("start event mismatch");
   chk_stop_pulse: assert property (act_stop == (~clock_presence_status & $past(clock_presence_status)))
      else $error("stop event mismatch");
   chk_one_answer: assert property (!(wr_accepted && wr_rejected))
      else $error("write both accepted and rejected");
   chk_reject_kept: assert property (wr_rejected && switch_busy == '0 |=> $stable(sel_state))
      else $error("rejected write changed selection");
   chk_sw_quick: assert property (sw_bounded(3))
      else $error("switch on output three too slow");
   chk_sw_forced: assert property (sw_bounded(11))
      else $error("switch on output eleven deadlocked");
   chk_low_in_switch: assert property (switch_busy[5] && $past(switch_busy[5]) |-> !$rose(base_clk[5]))
      else $error("edge during pll switch");
endmodule : bcg_top_monitor
`default_nettype wire

/* File: bcg_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bcg_src_model (
   input wire logic mclk,
   input wire logic [11:0] run,
   input wire logic [11:0] hold_hi,
   input wire logic lock_in,
   output logic ring_clk,
   output logic xtal_clk,
   output logic [2:0] pll_clks,
   output logic [6:0] div_clks,
   output logic lock_out
);
   // slow sources: the design samples them at mclk rate
   logic [7:0] ph_r = 8'h00;
   logic [11:0] lvl;
   always @(posedge mclk) ph_r <= ph_r + 8'h01;
   always_comb begin
      logic [7:0] t;
      t = 8'h00;
      for (int i = 0; i < 12; i++) begin
         t = ph_r + 8'(i);
         lvl[i] = run[i] ? t[2] : hold_hi[i];
      end
   end
   assign ring_clk = ph_r[2];
   assign xtal_clk = lvl[1];
   assign pll_clks = lvl[4:2];
   assign div_clks = lvl[11:5];
   assign lock_out = lock_in;
endmodule : bcg_src_model
`default_nettype wire

/* File: base_clock_generator_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module base_clock_generator_tb;
   logic mclk, rst, ce, ring_oscillator, crystal_clk, pll_lock, pll_ref_clk, ring_osc_enable;
   logic [2:0] pll_clk;
   logic [6:0] fractional_divider_clk, fractional_divider_src_clk;
   logic bridge_wr_toggle, bridge_wr_out_en, presence_valid, wr_accepted, wr_rejected;
   logic [4:0] bridge_wr_gen;
   logic [3:0] bridge_wr_sel;
   logic [11:0] base_clk, clock_presence_status, act_start, act_stop, run, hold_hi;
   logic [79:0] sel_state;
   logic [19:0] switch_busy;
   logic lock_req;
   int errors = 0;
   int n_checks = 0;
   bcg_top dut (.*);
   bcg_src_model src (.mclk(mclk), .run(run), .hold_hi(hold_hi), .lock_in(lock_req),
      .ring_clk(ring_oscillator), .xtal_clk(crystal_clk), .pll_clks(pll_clk),
      .div_clks(fractional_divider_clk), .lock_out(pll_lock));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // ----------------------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------------------
   task automatic tally_and_finish;
      if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // data settles 3 cycles before the toggle and stays after it
   task automatic wr(input logic [4:0] g, input logic [3:0] s, input logic oe, output logic acc);
      int i;
      @(posedge mclk);
      bridge_wr_gen <= g;
      bridge_wr_sel <= s;
      bridge_wr_out_en <= oe;
      repeat (3) @(posedge mclk);
      bridge_wr_toggle <= ~bridge_wr_toggle;
      for (i = 0; i < 12; i++) begin
         @(posedge mclk);
         #1;
         if (wr_accepted === 1'b1 || wr_rejected === 1'b1) break;
      end
      if (i == 12) begin
         errors++;
         tally_and_finish();
      end
      acc = wr_accepted;
      repeat (4) @(posedge mclk);
   endtask : wr
   task automatic wait_idle(input int g);
      int i;
      #1;
      for (i = 0; i < 80 && switch_busy[g] !== 1'b0; i++) begin
         @(posedge mclk);
         #1;
      end
      if (i == 80) begin
         errors++;
         tally_and_finish();
      end
   endtask : wait_idle
   // changes of generator g over 16 cycles; index as in the switch vector
   task automatic toggles(input int g, output int n);
      logic [19:0] v;
      logic last;
      n = 0;
      v = {pll_ref_clk, fractional_divider_src_clk, base_clk};
      last = v[g];
      repeat (16) begin
         @(posedge mclk);
         #1;
         v = {pll_ref_clk, fractional_divider_src_clk, base_clk};
         if (v[g] !== last) n++;
         last = v[g];
      end
   endtask : toggles
   // gen, source, accept expected
   logic [9:0] tab [13] = '{
      10'h023, // system clock to running crystal
      10'h002, // safe clock refuses crystal
      10'h044, // control clock refuses pll
      10'h140, // reserved index refused
      10'h264, // pll fed by own output
      10'h26A, // pll fed by divider
      10'h263, // pll from crystal
      10'h18A, // divider from divider
      10'h185, // divider from pll
      10'h06B, // output from divider
      10'h098, // source code out of range
      10'h163, // crystal shared
      10'h280};// index beyond last
   // ----------------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------------
   initial begin
      logic [4:0] g;
      logic [3:0] s, prev;
      logic e, acc;
      int n;
      rst = 1'b1;
      ce = 1'b1;
      bridge_wr_toggle = 1'b0;
      bridge_wr_gen = 5'h00;
      bridge_wr_sel = 4'h0;
      bridge_wr_out_en = 1'b1;
      run = 12'hFFF;
      hold_hi = 12'h000;
      lock_req = 1'b1;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      check("sel_state", sel_state, 80'h0);
      check("presence", {68'h0, clock_presence_status}, 80'h0);
      check("ring_en", {79'h0, ring_osc_enable}, 80'h1);
      repeat (40) @(posedge mclk);
      #1;
      check("valid", {79'h0, presence_valid}, 80'h1);
      check("present", {68'h0, clock_presence_status}, 80'hFFF);
      // frozen enable: a stalled crystal must not age its window
      @(posedge mclk);
      ce <= 1'b0;
      run[1] <= 1'b0;
      repeat (40) @(posedge mclk);
      #1;
      check("frozen", {68'h0, clock_presence_status}, 80'hFFF);
      @(posedge mclk);
      ce <= 1'b1;
      run[1] <= 1'b1;
      for (int k = 0; k < 13; k++) begin
         {g, s, e} = tab[k];
         prev = sel_state[g*4 +: 4];
         wr(g, s, 1'b1, acc);
         check("accept", {79'h0, acc}, {79'h0, e});
         if (g < 5'h14) begin
            wait_idle(g);
            check("selector", {76'h0, sel_state[g*4 +: 4]}, {76'h0, e ? s : prev});
         end
      end
      // running sources reach the outputs; a refused write still clears enable
      toggles(12, n);
      check("fdiv0_in", {79'h0, n > 0}, 80'h1);
      toggles(19, n);
      check("pll_ref", {79'h0, n > 0}, 80'h1);
      toggles(9, n);
      check("gen9_runs", {79'h0, n > 0}, 80'h1);
      wr(5'h09, 4'hC, 1'b0, acc);
      check("gen9_refused", {79'h0, acc}, 80'h0);
      toggles(9, n);
      check("gen9_gated", {79'h0, n == 0}, 80'h1);
      check("gen9_sel", {76'h0, sel_state[39:36]}, 80'h0);
      // stuck-high crystal: gens 1, 11 and 19 keep it, writes masked
      @(posedge mclk);
      run[1] <= 1'b0;
      hold_hi[1] <= 1'b1;
      #1;
      for (n = 0; n < 45 && act_stop[1] !== 1'b1; n++) begin
         @(posedge mclk);
         #1;
      end
      check("stop_delay", {79'h0, n >= 24 && n <= 38}, 80'h1);
      check("xtal_gone", {79'h0, clock_presence_status[1]}, 80'h0);
      check("kept_dead", {76'h0, sel_state[7:4]}, 80'h1);
      wr(5'h03, 4'h1, 1'b1, acc);
      check("masked", {79'h0, acc}, 80'h0);
      // gen 11 leaves its stuck-high crystal
      wr(5'h0B, 4'h0, 1'b1, acc);
      check("leave_ok", {79'h0, acc}, 80'h1);
      wait_idle(11);
      check("forced", {76'h0, sel_state[47:44]}, 80'h0);
      @(posedge mclk);
      run[1] <= 1'b1;
      repeat (12) @(posedge mclk);
      #1;
      check("xtal_back", {79'h0, clock_presence_status[1]}, 80'h1);
      wr(5'h03, 4'h1, 1'b1, acc);
      check("unmasked", {79'h0, acc}, 80'h1);
      wait_idle(3);
      // pll switch waits for lock
      @(posedge mclk);
      lock_req <= 1'b0;
      wr(5'h05, 4'h2, 1'b1, acc);
      check("pll_accept", {79'h0, acc}, 80'h1);
      repeat (20) @(posedge mclk);
      #1;
      check("pll_wait", {78'h0, switch_busy[5], base_clk[5]}, 80'h2);
      @(posedge mclk);
      lock_req <= 1'b1;
      wait_idle(5);
      check("pll_sel", {76'h0, sel_state[23:20]}, 80'h2);
      tally_and_finish();
   end
endmodule : base_clock_generator_tb
bind bcg_top bcg_top_monitor #(.NUM_OUT(NUM_OUT), .NUM_FRACTIONAL_DIVIDER(NUM_FRACTIONAL_DIVIDER)) mon (.*);
`default_nettype wire
